// ---- logic/ccsg_clock_ctrl.sv ----
// Oscillator source decode, CPU slowdown and per-module clock gating
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Source codes 111, 110 and 101 pick the fast RC divided by N, by 16, or the low-power RC.
// R2 - Code 011 runs the primary oscillator through the PLL and 010 directly, type from 10/01/00.
// R3 - Code 001 feeds the fast RC divided by N into the PLL and 000 uses the fast RC directly.
// R4 - Erased configuration starts in fast RC divided-by-N mode, source code 111.
// R5 - A dedicated configuration bit decides the function of the second oscillator pin.
// R6 - Slowdown enable at bit 11 divides only the CPU clock; system and peripherals keep speed.
// R7 - The ratio field at bits 14:12 selects one of eight ratios 1:1 to 1:128, default 1:1.
// R8 - With bit 15 set an interrupt returns the CPU to full speed; clear, interrupts do nothing.
// R9 - CPU and peripheral clock domains stay aligned so peripheral register access is valid.
// R10 - A set gate bit stops the module's clocks, drops its register writes, invalidates reads.
// R11 - A module runs only with its gate clear and when fitted; fitted gates reset to clear.
// R12 - A gate change reaches its module one instruction cycle later.
// R13 - Ratio codes 000 to 111 give CPU divisors 1, 2, 4, 8, 16, 32, 64 and 128.
// R14 - Ratio changes take effect only at CPU clock boundaries, with no runt pulse.
module ccsg_clock_ctrl
  import ccsg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_irq,
  input wire logic [15:0] i_periph_wr_req,
  input wire logic [15:0] i_periph_rd_req,
  output logic o_cpu_clk_en,
  output logic [15:0] o_periph_clk_en,
  output logic [15:0] o_periph_wr_en,
  output logic [15:0] o_periph_rd_valid,
  output logic [3:0] o_osc_mode,
  output logic o_src_primary,
  output logic o_pll_en,
  output logic o_rc_div_n_en,
  output logic o_rc_div16_en,
  output logic o_low_power_osc_en,
  output logic [1:0] o_primary_osc_type_sel,
  output logic o_second_osc_pin_function_sel
);

  ccsg_div_if div_bus ();

  // Clock divider register
  logic interrupt_restores_full_speed_q;
  logic core_slowdown_enable_q;
  logic core_slowdown_enable_d;
  logic [2:0] slow_ratio_q;

  // Oscillator configuration
  logic [2:0] osc_source_sel_q;
  logic [1:0] primary_osc_type_sel_q;
  logic second_osc_pin_function_sel_q;

  // Module gating
  logic [15:0] module_clock_gate_q;
  logic [15:0] module_active_q;
  logic [15:0] module_active_d;

  // Registered outputs
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  ccsg_osc_mode_t osc_mode_q;
  ccsg_osc_mode_t osc_mode_d;
  logic src_primary_q;
  logic pll_en_q;
  logic rc_div_n_q;
  logic rc_div16_q;
  logic low_power_q;
  logic pin_fn_q;

  // Address decode
  wire sel_clock_divider_register = (i_addr == CCSG_ADDR_CLOCK_DIVIDER_REGISTER);
  wire sel_osccfg = (i_addr == CCSG_ADDR_OSCCFG);
  wire sel_gate = (i_addr == CCSG_ADDR_GATE);
  wire sel_status = (i_addr == CCSG_ADDR_STATUS);
  wire sel_active = (i_addr == CCSG_ADDR_ACTIVE);
  wire wr_clock_divider_register = i_wr && sel_clock_divider_register;
  wire wr_osccfg = i_wr && sel_osccfg;
  wire wr_gate = i_wr && sel_gate;

  // Write data fields, named once so the register processes stay short
  wire wdata_roi = i_wdata[CCSG_ROI_BIT];
  wire wdata_slow_en = i_wdata[CCSG_SLOW_EN_BIT];
  wire [2:0] wdata_ratio = i_wdata[CCSG_RATIO_MSB:CCSG_RATIO_LSB];
  wire [2:0] wdata_src = i_wdata[CCSG_SRC_MSB:CCSG_SRC_LSB];
  wire [1:0] wdata_ptype = i_wdata[CCSG_PTYPE_MSB:CCSG_PTYPE_LSB];
  wire wdata_pin_fn = i_wdata[CCSG_PINFN_BIT];
  wire [15:0] wdata_gate = i_wdata & CCSG_PRESENT_MASK;

  // Interrupt restore: the hardware clear beats a same-cycle software set,
  // so an interrupt is never lost while the CPU crawls [R8]
  wire irq_restore = i_irq && interrupt_restores_full_speed_q;

  always_comb begin
    core_slowdown_enable_d = core_slowdown_enable_q;
    if (wr_clock_divider_register) begin
      core_slowdown_enable_d = wdata_slow_en;
    end
    if (irq_restore) begin
      core_slowdown_enable_d = 1'b0; // [R8]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      core_slowdown_enable_q <= 1'b0;
    end else begin
      core_slowdown_enable_q <= core_slowdown_enable_d; // [R6] [R8]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      interrupt_restores_full_speed_q <= 1'b0;
    end else if (wr_clock_divider_register) begin
      interrupt_restores_full_speed_q <= wdata_roi; // [R8]
    end
  end

  // Ratio is kept when an interrupt clears slowdown; every divider register write reloads it from bits 14:12, whatever bit 11
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      slow_ratio_q <= CCSG_RATIO_RST; // [R7]
    end else if (wr_clock_divider_register) begin
      slow_ratio_q <= wdata_ratio; // [R7]
    end
  end

  // Only the CPU enable is divided; system and peripheral clocks run on [R6]
  assign div_bus.req_ratio = core_slowdown_enable_q ? slow_ratio_q : 3'h0; // [R6]

  ccsg_slow_div u_slow_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .bus(div_bus)
  );

  assign o_cpu_clk_en = div_bus.cpu_en; // [R9]

  // Oscillator configuration; reset mirrors erased fuses [R4]
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      osc_source_sel_q <= CCSG_SRC_RST; // [R4]
    end else if (wr_osccfg) begin
      osc_source_sel_q <= wdata_src; // [R1] [R2] [R3]
    end
  end

  // Primary type is stored for every code but only decoded for 010 and 011
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      primary_osc_type_sel_q <= CCSG_PTYPE_RST;
    end else if (wr_osccfg) begin
      primary_osc_type_sel_q <= wdata_ptype; // [R2]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      second_osc_pin_function_sel_q <= CCSG_PINFN_RST;
    end else if (wr_osccfg) begin
      second_osc_pin_function_sel_q <= wdata_pin_fn; // [R5]
    end
  end

  // Primary type only matters for the primary codes
  ccsg_osc_mode_t pri_direct_mode;
  ccsg_osc_mode_t pri_pll_mode;

  always_comb begin
    case (primary_osc_type_sel_q)
      CCSG_PRI_HS_CRYSTAL: begin
        pri_direct_mode = CCSG_MODE_HIGH_SPEED_CRYSTAL;
        pri_pll_mode = CCSG_MODE_HIGH_SPEED_CRYSTAL_PLL;
      end
      CCSG_PRI_STD_CRYSTAL: begin
        pri_direct_mode = CCSG_MODE_STANDARD_CRYSTAL;
        pri_pll_mode = CCSG_MODE_STANDARD_CRYSTAL_PLL;
      end
      CCSG_PRI_EXT_CLOCK: begin
        pri_direct_mode = CCSG_MODE_EXTERNAL_CLOCK_INPUT;
        pri_pll_mode = CCSG_MODE_EXTERNAL_CLOCK_PLL;
      end
      default: begin
        // Primary oscillator switched off: no usable clock from it
        pri_direct_mode = CCSG_MODE_INVALID;
        pri_pll_mode = CCSG_MODE_INVALID;
      end
    endcase
  end

  always_comb begin
    case (osc_source_sel_q)
      CCSG_SRC_RC_DIVN: osc_mode_d = CCSG_MODE_INTERNAL_RC_DIV_N; // [R1]
      CCSG_SRC_RC_DIV16: osc_mode_d = CCSG_MODE_INTERNAL_RC_DIV_SIXTEEN; // [R1]
      CCSG_SRC_LOW_POWER: osc_mode_d = CCSG_MODE_LOW_POWER_INTERNAL; // [R1]
      CCSG_SRC_PRI_PLL: osc_mode_d = pri_pll_mode; // [R2]
      CCSG_SRC_PRI_DIRECT: osc_mode_d = pri_direct_mode; // [R2]
      CCSG_SRC_RC_PLL: osc_mode_d = CCSG_MODE_INTERNAL_RC_PLL; // [R3]
      CCSG_SRC_RC_DIRECT: osc_mode_d = CCSG_MODE_FAST_INTERNAL_OSC; // [R3]
      default: osc_mode_d = CCSG_MODE_INVALID;
    endcase
  end

  wire src_primary_d = (osc_source_sel_q == CCSG_SRC_PRI_PLL) ||
                       (osc_source_sel_q == CCSG_SRC_PRI_DIRECT); // [R2]
  wire pll_en_d = (osc_source_sel_q == CCSG_SRC_PRI_PLL) ||
                  (osc_source_sel_q == CCSG_SRC_RC_PLL); // [R2] [R3]
  // The internal RC PLL path (001) also uses the divide-by-N stage ahead of it
  wire rc_div_n_d = (osc_source_sel_q == CCSG_SRC_RC_DIVN) ||
                    (osc_source_sel_q == CCSG_SRC_RC_PLL); // [R1] [R3]
  wire rc_div16_d = (osc_source_sel_q == CCSG_SRC_RC_DIV16); // [R1]
  wire low_power_d = (osc_source_sel_q == CCSG_SRC_LOW_POWER); // [R1]

  // Decoded outputs are registered so they switch together, free of glitches
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      osc_mode_q <= CCSG_MODE_INTERNAL_RC_DIV_N; // [R4]
    end else begin
      osc_mode_q <= osc_mode_d; // [R1] [R2] [R3]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      src_primary_q <= 1'b0;
    end else begin
      src_primary_q <= src_primary_d; // [R2]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pll_en_q <= 1'b0;
    end else begin
      pll_en_q <= pll_en_d; // [R2] [R3]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rc_div_n_q <= 1'b1; // [R4]
    end else begin
      rc_div_n_q <= rc_div_n_d; // [R1] [R3]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rc_div16_q <= 1'b0;
    end else begin
      rc_div16_q <= rc_div16_d; // [R1]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= low_power_d; // [R1]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pin_fn_q <= CCSG_PINFN_RST;
    end else begin
      pin_fn_q <= second_osc_pin_function_sel_q; // [R5]
    end
  end

  assign o_osc_mode = osc_mode_q;
  assign o_src_primary = src_primary_q;
  assign o_pll_en = pll_en_q;
  assign o_rc_div_n_en = rc_div_n_q;
  assign o_rc_div16_en = rc_div16_q;
  assign o_low_power_osc_en = low_power_q;
  assign o_primary_osc_type_sel = primary_osc_type_sel_q;
  assign o_second_osc_pin_function_sel = pin_fn_q;

  // Module gates: absent modules keep their gate bits masked to zero and never run [R11]
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      module_clock_gate_q <= CCSG_GATE_RST; // [R11]
    end else if (wr_gate) begin
      module_clock_gate_q <= wdata_gate; // [R11]
    end
  end

  // The stage after the gate flop is the one instruction cycle of delay [R12]
  assign module_active_d = ~module_clock_gate_q & CCSG_PRESENT_MASK; // [R11]

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      module_active_q <= CCSG_PRESENT_MASK; // [R11]
    end else begin
      module_active_q <= module_active_d; // [R12]
    end
  end

  // A disabled module loses every clock and its register port [R10]
  assign o_periph_clk_en = module_active_q; // [R10]
  assign o_periph_wr_en = i_periph_wr_req & module_active_q; // [R10]
  assign o_periph_rd_valid = i_periph_rd_req & module_active_q; // [R10]

  // Register read path; data stands one cycle after the strobe only
  wire [15:0] clock_divider_register_view = {interrupt_restores_full_speed_q, slow_ratio_q,
                             core_slowdown_enable_q, 11'h000};
  wire [15:0] osccfg_view = {10'h000, second_osc_pin_function_sel_q,
                             primary_osc_type_sel_q, osc_source_sel_q};
  wire [15:0] status_view = {7'h00, pll_en_q, div_bus.cur_ratio,
                             core_slowdown_enable_q, osc_mode_q};

  // Read selects; no strobe or an unmapped index leaves the word at zero
  wire rd_clock_divider_register = i_rd && sel_clock_divider_register;
  wire rd_osccfg = i_rd && sel_osccfg;
  wire rd_gate = i_rd && sel_gate;
  wire rd_status = i_rd && sel_status;
  wire rd_active = i_rd && sel_active;

  always_comb begin
    if (rd_clock_divider_register) begin
      rdata_d = clock_divider_register_view;
    end else if (rd_osccfg) begin
      rdata_d = osccfg_view;
    end else if (rd_gate) begin
      rdata_d = module_clock_gate_q;
    end else if (rd_status) begin
      rdata_d = status_view;
    end else if (rd_active) begin
      rdata_d = module_active_q;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

// ---- logic/ccsg_pkg.sv ----
// Constants and types shared by the clock select, slowdown and gating block
package ccsg_pkg;

  // Register port geometry
  localparam int CCSG_ADDR_W = 4;
  localparam int CCSG_DATA_W = 16;
  localparam int CCSG_NUM_MODULES = 16;

  // Register indices on the plain register port
  localparam logic [3:0] CCSG_ADDR_CLOCK_DIVIDER_REGISTER = 4'h0;
  localparam logic [3:0] CCSG_ADDR_OSCCFG = 4'h1;
  localparam logic [3:0] CCSG_ADDR_GATE = 4'h2;
  localparam logic [3:0] CCSG_ADDR_STATUS = 4'h3;
  localparam logic [3:0] CCSG_ADDR_ACTIVE = 4'h4;

  // Clock divider register fields
  localparam int CCSG_SLOW_EN_BIT = 11;
  localparam int CCSG_RATIO_LSB = 12;
  localparam int CCSG_RATIO_MSB = 14;
  localparam int CCSG_ROI_BIT = 15;
  localparam logic [2:0] CCSG_RATIO_RST = 3'h0;
  localparam logic [15:0] CCSG_CLOCK_DIVIDER_REGISTER_MASK = 16'hF800;

  // Oscillator configuration register fields
  localparam int CCSG_SRC_LSB = 0;
  localparam int CCSG_SRC_MSB = 2;
  localparam int CCSG_PTYPE_LSB = 3;
  localparam int CCSG_PTYPE_MSB = 4;
  localparam int CCSG_PINFN_BIT = 5;
  // Erased configuration reads as all ones
  localparam logic [2:0] CCSG_SRC_RST = 3'h7;
  localparam logic [1:0] CCSG_PTYPE_RST = 2'h3;
  localparam logic CCSG_PINFN_RST = 1'b1;

  // Status register fields
  localparam int CCSG_ST_MODE_LSB = 0;
  localparam int CCSG_ST_MODE_MSB = 3;
  localparam int CCSG_ST_SLOW_BIT = 4;
  localparam int CCSG_ST_RLSB = 5;
  localparam int CCSG_ST_RMSB = 7;
  localparam int CCSG_ST_PLL_BIT = 8;

  // Modules fitted on this variant; absent ones never run
  localparam logic [15:0] CCSG_PRESENT_MASK = 16'h3FFF;
  localparam logic [15:0] CCSG_GATE_RST = 16'h0000;

  // Gate changes reach the module one instruction cycle later
  localparam int CCSG_GATE_DELAY_CYCLES = 1;

  typedef enum logic [2:0] {
    CCSG_SRC_RC_DIRECT = 3'b000,
    CCSG_SRC_RC_PLL = 3'b001,
    CCSG_SRC_PRI_DIRECT = 3'b010,
    CCSG_SRC_PRI_PLL = 3'b011,
    CCSG_SRC_RSVD = 3'b100,
    CCSG_SRC_LOW_POWER = 3'b101,
    CCSG_SRC_RC_DIV16 = 3'b110,
    CCSG_SRC_RC_DIVN = 3'b111
  } ccsg_osc_source_sel_t;

  typedef enum logic [1:0] {
    CCSG_PRI_EXT_CLOCK = 2'b00,
    CCSG_PRI_STD_CRYSTAL = 2'b01,
    CCSG_PRI_HS_CRYSTAL = 2'b10,
    CCSG_PRI_OFF = 2'b11
  } ccsg_primary_osc_type_sel_t;

  typedef enum logic [3:0] {
    CCSG_MODE_FAST_INTERNAL_OSC = 4'h0,
    CCSG_MODE_INTERNAL_RC_PLL = 4'h1,
    CCSG_MODE_HIGH_SPEED_CRYSTAL = 4'h2,
    CCSG_MODE_STANDARD_CRYSTAL = 4'h3,
    CCSG_MODE_EXTERNAL_CLOCK_INPUT = 4'h4,
    CCSG_MODE_HIGH_SPEED_CRYSTAL_PLL = 4'h5,
    CCSG_MODE_STANDARD_CRYSTAL_PLL = 4'h6,
    CCSG_MODE_EXTERNAL_CLOCK_PLL = 4'h7,
    CCSG_MODE_LOW_POWER_INTERNAL = 4'h8,
    CCSG_MODE_INTERNAL_RC_DIV_SIXTEEN = 4'h9,
    CCSG_MODE_INTERNAL_RC_DIV_N = 4'hA,
    CCSG_MODE_INVALID = 4'hF
  } ccsg_osc_mode_t;

endpackage

// ---- logic/ccsg_div_if.sv ----
// Carrier between the control logic and the CPU clock divider
`timescale 1ns/1ps
`default_nettype none
interface ccsg_div_if;
  logic [2:0] req_ratio;
  logic [2:0] cur_ratio;
  logic cpu_en;
  modport ctrl (output req_ratio, input cur_ratio, input cpu_en);
  modport div (input req_ratio, output cur_ratio, output cpu_en);
endinterface
`default_nettype wire

// ---- logic/ccsg_slow_div.sv ----
// CPU clock enable divider that switches ratio only on CPU cycle boundaries
`timescale 1ns/1ps
`default_nettype none
module ccsg_slow_div
  import ccsg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  ccsg_div_if.div bus
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [2:0] ratio_q;
  logic [2:0] ratio_d;
  logic [7:0] divisor;
  wire boundary = (cnt_q == 7'h00);

  // Ratio code n divides by two to the n, 1 up to 128 [R13]
  assign divisor = 8'h01 << bus.req_ratio;
  // New ratio is picked up only where a CPU cycle ends, so no runt pulse [R14]
  assign ratio_d = boundary ? bus.req_ratio : ratio_q;
  assign cnt_d = boundary ? 7'(divisor - 8'h01) : 7'(cnt_q - 7'h01);
  // Enable lands on the same master edges the peripherals use [R9]
  assign bus.cpu_en = boundary;
  assign bus.cur_ratio = ratio_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cnt_q <= 7'h00;
      ratio_q <= CCSG_RATIO_RST;
    end else begin
      cnt_q <= cnt_d;
      ratio_q <= ratio_d;
    end
  end

endmodule
`default_nettype wire

// ---- tb/ccsg_clock_ctrl_props.sv ----
// Concurrent checks on the ports of the clock control block
`timescale 1ns/1ps
`default_nettype none
module ccsg_clock_ctrl_props
  import ccsg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_irq,
  input wire logic [15:0] i_periph_wr_req,
  input wire logic [15:0] i_periph_rd_req,
  input wire logic o_cpu_clk_en,
  input wire logic [15:0] o_periph_clk_en,
  input wire logic [15:0] o_periph_wr_en,
  input wire logic [15:0] o_periph_rd_valid,
  input wire logic [3:0] o_osc_mode,
  input wire logic o_src_primary,
  input wire logic o_pll_en,
  input wire logic o_rc_div_n_en,
  input wire logic o_low_power_osc_en,
  input wire logic o_second_osc_pin_function_sel
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] gap_q;
  logic restore_q;
  wire gate_wr = i_wr && i_addr == CCSG_ADDR_GATE;
  wire cfg_wr = i_wr && i_addr == CCSG_ADDR_OSCCFG;
  // Gap saturates so a stalled divider cannot wrap into a legal value
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || o_cpu_clk_en) gap_q <= 8'h01;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    if (!i_rst_b) restore_q <= 1'b0;
    else if (i_wr && i_addr == CCSG_ADDR_CLOCK_DIVIDER_REGISTER) restore_q <= i_wdata[CCSG_ROI_BIT];
  end
  a_wr_blocked: assert property (o_periph_wr_en == (i_periph_wr_req & o_periph_clk_en))
    else $error("module write passed while gated");
  a_rd_blocked: assert property (o_periph_rd_valid == (i_periph_rd_req & o_periph_clk_en))
    else $error("module read valid while gated");
  a_absent_idle: assert property (o_periph_clk_en[15:14] == 2'h0)
    else $error("absent module clocked");
  a_gate_delay: assert property (gate_wr ##1 !gate_wr |-> ##1
    o_periph_clk_en == (~$past(i_wdata, 2) & CCSG_PRESENT_MASK))
    else $error("gate change not seen one cycle after register");
  a_gate_hold: assert property ($changed(o_periph_clk_en) |-> $past(gate_wr, 2))
    else $error("module enable moved without gate write");
  a_cpu_gap: assert property (o_cpu_clk_en |-> $onehot(gap_q) && gap_q <= 8'h80)
    else $error("cpu enable gap not a legal ratio");
  a_irq_restore: assert property (restore_q && i_irq |-> ##[1:130] o_cpu_clk_en [*3])
    else $error("interrupt did not restore full speed");
  a_lp_select: assert property (cfg_wr && i_wdata[2:0] == 3'h5 |-> ##2
    o_low_power_osc_en && !o_pll_en && !o_src_primary)
    else $error("low power source not selected");
  a_pri_pll: assert property (cfg_wr && i_wdata[2:0] == 3'h3 && i_wdata[4:3] != 2'h3
    |-> ##2 o_pll_en && o_src_primary)
    else $error("primary with pll not selected");
  a_rc_pll: assert property (cfg_wr && i_wdata[2:0] == 3'h1 |-> ##2
    o_pll_en && o_rc_div_n_en && !o_src_primary)
    else $error("internal rc with pll not selected");
  a_reset_mode: assert property ($rose(i_rst_b) |-> o_osc_mode == 4'hA && o_rc_div_n_en)
    else $error("wrong oscillator mode after reset");
  a_pin_func: assert property (cfg_wr |-> ##2
    o_second_osc_pin_function_sel == $past(i_wdata[CCSG_PINFN_BIT], 2))
    else $error("pin function bit not followed");
  c_slowest: cover property (o_cpu_clk_en && gap_q == 8'h80);
  c_restore: cover property (restore_q && i_irq);
  c_gated: cover property (gate_wr ##2 o_periph_clk_en != CCSG_PRESENT_MASK);
endmodule
bind ccsg_clock_ctrl ccsg_clock_ctrl_props u_ccsg_clock_ctrl_props (.*);
`default_nettype wire

// ---- tb/ccsg_clock_ctrl_test.sv ----
// Self-checking bench for the clock select, slowdown and gating block
`timescale 1ns/1ps
`default_nettype none
module ccsg_clock_ctrl_test;
  import ccsg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_irq = 1'b0;
  // Mixed request patterns so the gating AND is visible on both outputs
  logic [15:0] i_periph_wr_req = 16'hF0F1;
  logic [15:0] i_periph_rd_req = 16'h3C3D;
  logic [15:0] o_rdata, o_periph_clk_en, o_periph_wr_en, o_periph_rd_valid;
  logic o_cpu_clk_en, o_src_primary, o_pll_en, o_rc_div_n_en, o_rc_div16_en;
  logic o_low_power_osc_en, o_second_osc_pin_function_sel;
  logic [3:0] o_osc_mode;
  logic [1:0] o_primary_osc_type_sel;
  int n_fail = 0;
  int checked = 0;
  always #25 i_mclk = ~i_mclk;
  ccsg_clock_ctrl u_ccsg_clock_ctrl (.*);
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask
  // Sampled mid-cycle so the enable has settled
  task automatic pulse_gap(output int gap);
    gap = 0;
    do begin
      @(negedge i_mclk);
      gap++;
    end while (o_cpu_clk_en !== 1'b1 && gap < 300);
    if (gap >= 300) begin
      n_fail++;
      conclude();
    end
  endtask
  // First gap may still belong to the old ratio, so skip two
  task automatic cpu_period(input int exp);
    int g;
    repeat (3) pulse_gap(g);
    chk("cpu gap", 16'(exp), 16'(g));
  endtask
  initial begin
    logic [9:0] t [13];
    logic [2:0] s;
    // Each entry: pll, expected mode, primary type, source code
    t = '{10'h15F, 10'h13E, 10'h11D, 10'h2B3, 10'h2CB, 10'h2E3, 10'h052,
          10'h06A, 10'h082, 10'h239, 10'h018, 10'h1FC, 10'h1FA};
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h0000, "divider reset");
    rd(CCSG_ADDR_OSCCFG, 16'h003F, "config reset");
    rd(CCSG_ADDR_GATE, 16'h0000, "gate reset");
    rd(CCSG_ADDR_STATUS, 16'h000A, "status reset");
    rd(CCSG_ADDR_ACTIVE, 16'h3FFF, "active reset");
    rd(4'hF, 16'h0000, "unmapped");
    for (int i = 0; i < 13; i++) begin
      s = t[i][2:0];
      wr(CCSG_ADDR_OSCCFG, {10'h000, 1'(i), t[i][4:0]});
      repeat (2) @(posedge i_mclk);
      #1 chk("mode", {12'h000, t[i][8:5]}, {12'h000, o_osc_mode});
      chk("pin function", 16'(i % 2), {15'h0, o_second_osc_pin_function_sel});
      chk("primary type", {14'h0, t[i][4:3]}, {14'h0, o_primary_osc_type_sel});
      if (t[i][8:5] != 4'hF) begin
        chk("pll", {15'h0, t[i][9]}, {15'h0, o_pll_en});
        chk("primary", {15'h0, s[2:1] == 2'h1}, {15'h0, o_src_primary});
        chk("low power", {15'h0, s == 3'h5}, {15'h0, o_low_power_osc_en});
        chk("div16", {15'h0, s == 3'h6}, {15'h0, o_rc_div16_en});
        chk("div n", {15'h0, s == 3'h7 || s == 3'h1}, {15'h0, o_rc_div_n_en});
      end
    end
    for (int r = 0; r < 8; r++) begin
      wr(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, {1'b0, r[2:0], 1'b1, 11'h000});
      cpu_period(1 << r);
      chk("periph clocks", 16'h3FFF, o_periph_clk_en);
    end
    wr(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h7000);
    cpu_period(1);
    wr(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'hB800);
    cpu_period(8);
    @(posedge i_mclk) i_irq <= 1'b1;
    @(posedge i_mclk) i_irq <= 1'b0;
    rd(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'hB000, "restore clears slowdown");
    cpu_period(1);
    wr(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h3800);
    cpu_period(8);
    @(posedge i_mclk) i_irq <= 1'b1;
    @(posedge i_mclk) i_irq <= 1'b0;
    rd(CCSG_ADDR_CLOCK_DIVIDER_REGISTER, 16'h3800, "interrupt ignored");
    cpu_period(8);
    rd(CCSG_ADDR_STATUS, 16'h007F, "status slowed");
    wr(CCSG_ADDR_GATE, 16'hFFFF);
    #1 chk("clock before delay", 16'h3FFF, o_periph_clk_en);
    @(posedge i_mclk);
    #1 chk("clock gated", 16'h0000, o_periph_clk_en);
    chk("writes blocked", 16'h0000, o_periph_wr_en);
    chk("reads invalid", 16'h0000, o_periph_rd_valid);
    rd(CCSG_ADDR_GATE, 16'h3FFF, "gate absent bits");
    rd(CCSG_ADDR_ACTIVE, 16'h0000, "active gated");
    wr(CCSG_ADDR_GATE, 16'h0001);
    @(posedge i_mclk);
    #1 chk("one gated", 16'h3FFE, o_periph_clk_en);
    chk("one write blocked", 16'h30F0, o_periph_wr_en);
    chk("one read invalid", 16'h3C3C, o_periph_rd_valid);
    @(posedge i_mclk) i_periph_wr_req <= 16'h0F0F;
    #1 chk("write request follows", 16'h0F0E, o_periph_wr_en);
    @(posedge i_mclk) i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(CCSG_ADDR_ACTIVE, 16'h3FFF, "active after reset");
    conclude();
  end
endmodule
`default_nettype wire
